// file: fpgen_consts.vh
// Purpose: constants for the frame pulse generator and back-channel slot mapping
// Assumes: byte-wide configuration registers at 8-bit offsets
// Notes:   reset values not given by the register map are plain choices
`ifndef FPGEN_CONSTS_VH
`define FPGEN_CONSTS_VH

`define REG_PIN_LEVEL_STATUS       8'h0E
`define REG_PIN_INPUT_DISABLE      8'h0F
`define REG_FRAME_PULSE_CONTROL    8'h18
`define REG_PULSE_HIGH_UPPER       8'h19
`define REG_PULSE_HIGH_LOWER       8'h1A
`define REG_PULSE_LOW_UPPER        8'h1B
`define REG_PULSE_LOW_LOWER        8'h1C
`define REG_BACKCHANNEL_RATE       8'h58
`define REG_SLOT_MAP_A             8'h6E
`define REG_SLOT_MAP_B             8'h6F
`define REG_PIN_PULLDOWN_DISABLE   8'hBE
`define REG_PORT_SELECT            8'h4C

// control register fields
`define CTL_GEN_ON_BIT             0
`define CTL_DUTY_MODE_BIT          1
`define CTL_START_LEVEL_BIT        2
`define CTL_SOURCE_MSB             7
`define CTL_SOURCE_LSB             4

// pulse source codes
`define SRC_PORT0_FRAME            4'h0
`define SRC_PORT1_FRAME            4'h1
`define SRC_PIN_FIRST              4'h8
`define SRC_PIN_LAST               4'hB

// slot map codes, 4 bits per slot: 0..3 pin, 0xA frame pulse
`define SLOT_SEL_PULSE             4'hA

// rate select code for 2.5 Mbps
`define RATE_2M5                   3'h0

// tick timing at 2.5 Mbps: 30-bit frame, 400 ns per bit
`define BC_BIT_NS                  400
`define BC_FRAME_BITS              30
`define CLK_PERIOD_NS              10

// reset values
`define RST_INPUT_DISABLE          8'h00
`define RST_PULLDOWN_DISABLE       8'h00
`define RST_CONTROL                8'h00
`define RST_SLOT_MAP               8'h00
`define RST_RATE                   8'h00

`endif

// file: frame_pulse_backchannel_gpio.v
// Purpose: frame pulse generator and back-channel GPIO slot mapping, two receive ports
// Assumes: register port is a simple byte strobe interface; pins synchronous to i_clk
// Notes:   port-local registers are addressed through the port select register
`timescale 1ns/1ps
`include "fpgen_consts.vh"

// Notes on behaviour
// - four general-purpose pins, each with control
// - any slot of each port carries any pin
// - one pin may feed many slots
// - any slot may carry frame pulse
// - status reads live pin levels always
// - input and pulldown disables, both cleared at reset so inputs and pulldowns are enabled
// - source 0x8..0xB forwards pin when generator off
// - generator enable bit starts internal pulse
// - tick equals back-channel frame period, 12 us
// - pulse repeats continuously until disabled
// - upper nibble selects tick source, 0 port 0
// - duty mode 0 uses separate high/low counts
// - phase lengths are count times tick period, one tick for a count of 0
// - 16-bit counts split upper/lower byte registers
// - start level bit sets first output level
// - rate code 0 selects 2.5 Mbps
module frame_pulse_backchannel_gpio #(
	parameter integer PIN_COUNT   = 4,
	parameter integer PORT_COUNT  = 2,
	parameter integer SLOT_COUNT  = 4,
	parameter integer FRAME_NS    = `BC_BIT_NS * `BC_FRAME_BITS,
	parameter integer FRAME_TICKS = FRAME_NS / `CLK_PERIOD_NS
) (
	input  wire                             i_clk,
	input  wire                             i_rst,
	input  wire                             i_reg_wr,
	input  wire                             i_reg_rd,
	input  wire [7:0]                       i_reg_addr,
	input  wire [7:0]                       i_reg_wdata,
	output reg  [7:0]                       o_reg_rdata,
	input  wire [PIN_COUNT-1:0]             i_pin_level,
	output wire [PIN_COUNT-1:0]             o_pin_input_en,
	output wire [PIN_COUNT-1:0]             o_pin_pulldown_en,
	output reg  [PORT_COUNT*SLOT_COUNT-1:0] o_backchannel_slot,
	output reg                              o_frame_pulse
);
	reg  [7:0] pin_input_disable;
	reg  [7:0] pin_pulldown_disable;
	reg  [7:0] frame_pulse_control;
	reg  [7:0] pulse_high_count_upper;
	reg  [7:0] pulse_high_count_lower;
	reg  [7:0] pulse_low_count_upper;
	reg  [7:0] pulse_low_count_lower;
	reg  [7:0] port_select;
	reg  [7:0] backchannel_rate_select [0:PORT_COUNT-1];
	reg  [7:0] backchannel_slot_map_a  [0:PORT_COUNT-1];
	reg  [7:0] backchannel_slot_map_b  [0:PORT_COUNT-1];
	reg  [15:0] phase_count;
	reg         gen_was_on;
	reg  [3:0]  pin_qual;
	wire [PORT_COUNT-1:0] port_tick;
	wire        pulse_generator_on;
	wire        duty_mode_sel;
	wire        pulse_start_level;
	wire [3:0]  pulse_source_sel;
	wire [15:0] pulse_high_count;
	wire [15:0] pulse_low_count;
	wire [15:0] half_count;
	wire        gen_tick;
	wire        pulse_value;
	reg  [15:0] phase_target;
	wire [PORT_COUNT*SLOT_COUNT-1:0] next_slot;
	integer     p;

	assign pulse_generator_on = frame_pulse_control[`CTL_GEN_ON_BIT];
	assign duty_mode_sel      = frame_pulse_control[`CTL_DUTY_MODE_BIT];
	assign pulse_start_level  = frame_pulse_control[`CTL_START_LEVEL_BIT];
	assign pulse_source_sel   = frame_pulse_control[`CTL_SOURCE_MSB:`CTL_SOURCE_LSB];
	assign pulse_high_count   = {pulse_high_count_upper, pulse_high_count_lower};
	assign pulse_low_count    = {pulse_low_count_upper, pulse_low_count_lower};
	// 50/50 mode sums the halved high and low counts, each rounded down
	assign half_count = (pulse_high_count >> 1) + (pulse_low_count >> 1);

	// disabled input is low on the slots and pulse path; pulldown control is an analog pad enable
	assign o_pin_input_en    = ~pin_input_disable[PIN_COUNT-1:0];
	assign o_pin_pulldown_en = ~pin_pulldown_disable[PIN_COUNT-1:0];

	// port select: bit0 port 0, bit1 port 1; first set bit wins on read
	function integer port_index;
		input [7:0] sel;
		begin
			port_index = (sel[1] && !sel[0]) ? 1 : 0;
		end
	endfunction

	// slot code decode: pins, pulse, otherwise low
	function slot_value;
		input [3:0] code;
		input [3:0] pins;
		input       pulse;
		begin
			if (code == `SLOT_SEL_PULSE)
				slot_value = pulse;
			else if (code < 4'h4)
				slot_value = pins[code[1:0]];
			else
				slot_value = 1'b0;
		end
	endfunction

	// slot index to its code nibble within the two map registers
	function [3:0] slot_code;
		input [7:0]   map_a;
		input [7:0]   map_b;
		input integer idx;
		begin
			case (idx)
				0:       slot_code = map_a[3:0];
				1:       slot_code = map_a[7:4];
				2:       slot_code = map_b[3:0];
				default: slot_code = map_b[7:4];
			endcase
		end
	endfunction

	genvar gp;
	generate
		for (gp = 0; gp < PORT_COUNT; gp = gp + 1) begin : g_tick
			pulse_tick_divider #(
				.FRAME_CYCLES(FRAME_TICKS)
			) u_div (
				.i_clk      (i_clk),
				.i_rst      (i_rst),
				.i_rate_sel (backchannel_rate_select[gp][2:0]),
				.o_tick     (port_tick[gp])
			);
		end
	endgenerate

	assign gen_tick = (pulse_source_sel == `SRC_PORT1_FRAME) ? port_tick[1]
		: port_tick[0];

	always @(posedge i_clk) begin
		if (i_rst) begin
			pin_input_disable      <= `RST_INPUT_DISABLE;
			pin_pulldown_disable   <= `RST_PULLDOWN_DISABLE;
			frame_pulse_control    <= `RST_CONTROL;
			pulse_high_count_upper <= 8'h00;
			pulse_high_count_lower <= 8'h00;
			pulse_low_count_upper  <= 8'h00;
			pulse_low_count_lower  <= 8'h00;
			port_select            <= 8'h01;
			for (p = 0; p < PORT_COUNT; p = p + 1) begin
				backchannel_rate_select[p] <= `RST_RATE;
				backchannel_slot_map_a[p]  <= `RST_SLOT_MAP;
				backchannel_slot_map_b[p]  <= `RST_SLOT_MAP;
			end
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				`REG_PIN_INPUT_DISABLE:     pin_input_disable <= i_reg_wdata;
				`REG_PIN_PULLDOWN_DISABLE:  pin_pulldown_disable <= i_reg_wdata;
				`REG_FRAME_PULSE_CONTROL:   frame_pulse_control <= i_reg_wdata;
				`REG_PULSE_HIGH_UPPER:      pulse_high_count_upper <= i_reg_wdata;
				`REG_PULSE_HIGH_LOWER:      pulse_high_count_lower <= i_reg_wdata;
				`REG_PULSE_LOW_UPPER:       pulse_low_count_upper <= i_reg_wdata;
				`REG_PULSE_LOW_LOWER:       pulse_low_count_lower <= i_reg_wdata;
				`REG_PORT_SELECT:           port_select <= i_reg_wdata;
				default: begin
					// port-local writes go to every selected port at once
					for (p = 0; p < PORT_COUNT; p = p + 1) begin
						if (port_select[p]) begin
							if (i_reg_addr == `REG_BACKCHANNEL_RATE)
								backchannel_rate_select[p] <= i_reg_wdata;
							if (i_reg_addr == `REG_SLOT_MAP_A)
								backchannel_slot_map_a[p] <= i_reg_wdata;
							if (i_reg_addr == `REG_SLOT_MAP_B)
								backchannel_slot_map_b[p] <= i_reg_wdata;
						end
					end
				end
			endcase
		end
	end

	always @* begin
		o_reg_rdata = 8'h00;
		if (i_reg_rd) begin
			case (i_reg_addr)
				`REG_PIN_LEVEL_STATUS:      o_reg_rdata = {4'h0, i_pin_level};
				`REG_PIN_INPUT_DISABLE:     o_reg_rdata = pin_input_disable;
				`REG_PIN_PULLDOWN_DISABLE:  o_reg_rdata = pin_pulldown_disable;
				`REG_FRAME_PULSE_CONTROL:   o_reg_rdata = frame_pulse_control;
				`REG_PULSE_HIGH_UPPER:      o_reg_rdata = pulse_high_count_upper;
				`REG_PULSE_HIGH_LOWER:      o_reg_rdata = pulse_high_count_lower;
				`REG_PULSE_LOW_UPPER:       o_reg_rdata = pulse_low_count_upper;
				`REG_PULSE_LOW_LOWER:       o_reg_rdata = pulse_low_count_lower;
				`REG_PORT_SELECT:           o_reg_rdata = port_select;
				`REG_BACKCHANNEL_RATE:
					o_reg_rdata = backchannel_rate_select[port_index(port_select)];
				`REG_SLOT_MAP_A:
					o_reg_rdata = backchannel_slot_map_a[port_index(port_select)];
				`REG_SLOT_MAP_B:
					o_reg_rdata = backchannel_slot_map_b[port_index(port_select)];
				default:                    o_reg_rdata = 8'h00;
			endcase
		end
	end

	// length of the running phase in ticks; 50/50 mode uses one length for both
	always @* begin
		if (duty_mode_sel)
			phase_target = half_count;
		else if (o_frame_pulse)
			phase_target = pulse_high_count;
		else
			phase_target = pulse_low_count;
	end

	// internal generator: counts ticks per phase, toggles, reloads the other phase
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_frame_pulse <= 1'b0;
			phase_count   <= 16'h0000;
			gen_was_on    <= 1'b0;
		end else if (!pulse_generator_on) begin
			o_frame_pulse <= pulse_start_level;
			phase_count   <= 16'h0000;
			gen_was_on    <= 1'b0;
		end else if (!gen_was_on) begin
			gen_was_on    <= 1'b1;
			o_frame_pulse <= pulse_start_level;
			phase_count   <= 16'h0000;
		end else if (gen_tick) begin
			// phase ends after count ticks; a zero count still lasts one tick
			if (phase_count + 16'h0001 >= phase_target) begin
				o_frame_pulse <= ~o_frame_pulse;
				phase_count   <= 16'h0000;
			end else begin
				phase_count   <= phase_count + 16'h0001;
			end
		end
	end

	always @(posedge i_clk) begin
		if (i_rst)
			pin_qual <= 4'h0;
		else
			pin_qual <= i_pin_level[3:0] & ~pin_input_disable[3:0];
	end

	// external mode forwards the chosen pin; generator output otherwise
	assign pulse_value = (!pulse_generator_on && pulse_source_sel >= `SRC_PIN_FIRST
		&& pulse_source_sel <= `SRC_PIN_LAST) ? pin_qual[pulse_source_sel[1:0]]
		: o_frame_pulse;

	// each slot reads its 4-bit code; map a holds slots 0-1, map b slots 2-3
	genvar gs;
	generate
		for (gp = 0; gp < PORT_COUNT; gp = gp + 1) begin : g_port
			for (gs = 0; gs < SLOT_COUNT; gs = gs + 1) begin : g_slot
				assign next_slot[gp*SLOT_COUNT + gs] = slot_value(
					slot_code(backchannel_slot_map_a[gp], backchannel_slot_map_b[gp], gs),
					pin_qual, pulse_value);
			end
		end
	endgenerate

	// registered so the far end never sees a decode glitch between codes
	always @(posedge i_clk) begin
		if (i_rst)
			o_backchannel_slot <= {(PORT_COUNT*SLOT_COUNT){1'b0}};
		else
			o_backchannel_slot <= next_slot;
	end
endmodule

// file: frame_pulse_backchannel_gpio_test.sv
// Purpose: self-checking bench for the frame pulse generator and slot mapping
// Assumes: tick count shortened to 8 cycles, rate code 0, tick source port 0
// Notes:   the driver notes each expectation, a negedge monitor checks it
`timescale 1ns/1ps
module frame_pulse_backchannel_gpio_test;
	localparam integer FT = 8;
	typedef struct {int kind; logic [15:0] v;} note_t;
	note_t       q[$];
	note_t       n;
	logic        i_clk = 0, i_rst = 1, i_reg_wr = 0, i_reg_rd = 0, look = 0, o_frame_pulse;
	logic [7:0]  i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata, o_backchannel_slot;
	logic [3:0]  i_pin_level = 4'h0, o_pin_input_en, o_pin_pulldown_en, seen0, seen1;
	logic [15:0] m0, m1;
	logic [31:0] seed = 32'h00011A20;
	logic [7:0]  cnt[4] = '{8'h01, 8'h02, 8'h00, 8'h03};
	int          error_cnt = 0, tests_run = 0, k;
	string       nm[6] = '{"rdata", "slot", "pulse", "length_a", "length_b", "pin_enables"};
	frame_pulse_backchannel_gpio #(.FRAME_TICKS(FT)) DUT (.i_clk(i_clk), .i_rst(i_rst),
		.i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
		.i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_pin_level(i_pin_level),
		.o_pin_input_en(o_pin_input_en), .o_pin_pulldown_en(o_pin_pulldown_en),
		.o_backchannel_slot(o_backchannel_slot), .o_frame_pulse(o_frame_pulse));
	remote_serializer_model P0 (.i_clk(i_clk), .i_rst(i_rst), .i_slot(o_backchannel_slot[3:0]),
		.o_seen(seen0));
	remote_serializer_model P1 (.i_clk(i_clk), .i_rst(i_rst), .i_slot(o_backchannel_slot[7:4]),
		.o_seen(seen1));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
	endtask
	task automatic expect_out(input int kind, input logic [15:0] v, input logic [7:0] a = 8'h00);
		@(posedge i_clk);
		q.push_back('{kind, v});
		look <= 1'b1;
		i_reg_rd <= (kind == 0);
		i_reg_addr <= a;
		@(posedge i_clk);
		look <= 1'b0;
		i_reg_rd <= 1'b0;
	endtask
	task automatic settle();
		repeat (4) @(posedge i_clk);
	endtask
	// counts negedges spent at lvl; called on the negedge where lvl was first seen
	task automatic phase(input logic lvl, output logic [15:0] m);
		int i;
		m = 0;
		for (i = 0; i < 5000 && o_frame_pulse === lvl; i++) begin
			@(negedge i_clk);
			m++;
		end
		if (i == 5000) begin
			error_cnt++;
			print_verdict();
		end
	endtask
	always @(negedge i_clk) begin
		if (look) begin
			n = q.pop_front();
			case (n.kind)
				0: check(nm[0], {8'h00, o_reg_rdata}, n.v);
				1: check(nm[1], {8'h00, seen1, seen0}, n.v);
				2: check(nm[2], {15'h0000, o_frame_pulse}, n.v);
				3: check(nm[3], m0, n.v);
				4: check(nm[4], m1, n.v);
				default: check(nm[5], {8'h00, o_pin_pulldown_en, o_pin_input_en}, n.v);
			endcase
		end
	end
	initial begin
		forever #5 i_clk = ~i_clk;
	end
	initial begin
		repeat (12) @(posedge i_clk);
		i_rst <= 1'b0;
		expect_out(0, 16'h0000, 8'h0F);
		expect_out(0, 16'h0000, 8'hBE);
		expect_out(5, 16'h00FF);
		for (k = 0; k < 4; k++) begin
			seed = xs(seed);
			wr(8'h0F, {4'h0, seed[3:0]});
			wr(8'hBE, {4'h0, seed[7:4]});
			i_pin_level <= seed[11:8];
			wr(8'h0E, 8'h0F);
			expect_out(0, {12'h000, seed[3:0]}, 8'h0F);
			expect_out(0, {12'h000, seed[7:4]}, 8'hBE);
			expect_out(0, {12'h000, seed[11:8]}, 8'h0E);
			expect_out(5, {8'h00, ~seed[7:4], ~seed[3:0]});
		end
		$display("pin controls and status done");
		wr(8'h0F, 8'h00);
		wr(8'h4C, 8'h03);
		for (k = 0; k < 4; k++) begin
			seed = xs(seed);
			i_pin_level <= seed[3:0];
			wr(8'h6E, {2{k[3:0]}});
			wr(8'h6F, {2{k[3:0]}});
			settle();
			expect_out(1, {8'h00, {8{seed[k]}}});
		end
		wr(8'h6E, 8'h10);
		wr(8'h6F, 8'h32);
		settle();
		expect_out(1, {8'h00, {2{seed[3:0]}}});
		// pins 0 and 2 with their input path off must read low on every slot
		wr(8'h0F, 8'h05);
		settle();
		expect_out(1, {8'h00, {2{seed[3:0] & 4'hA}}});
		wr(8'h0F, 8'h00);
		$display("slot mapping done");
		wr(8'h6E, 8'hAA);
		wr(8'h6F, 8'hAA);
		for (k = 0; k < 4; k++) begin
			seed = xs(seed);
			i_pin_level <= seed[3:0];
			wr(8'h18, {k[3:0] + 4'h8, 4'h0});
			settle();
			expect_out(1, {8'h00, {8{seed[k]}}});
		end
		$display("external pulse done");
		wr(8'h18, 8'h04);
		wr(8'h4C, 8'h01);
		wr(8'h58, 8'h00);
		for (k = 0; k < 4; k++)
			wr(8'h19 + k[7:0], cnt[k]);
		settle();
		expect_out(1, 16'h00FF);
		wr(8'h18, 8'h05);
		expect_out(2, 16'h0001);
		@(negedge i_clk);
		phase(1'b1, m0);
		phase(1'b0, m0);
		phase(1'b1, m1);
		expect_out(3, 3 * FT);
		expect_out(4, 258 * FT);
		// the low phase is already under way, so let it finish before counting
		@(negedge i_clk);
		phase(1'b0, m0);
		phase(1'b1, m1);
		phase(1'b0, m0);
		expect_out(3, 3 * FT);
		expect_out(4, 258 * FT);
		$display("separate high and low done");
		wr(8'h18, 8'h06);
		wr(8'h18, 8'h07);
		@(negedge i_clk);
		phase(1'b1, m0);
		phase(1'b0, m0);
		phase(1'b1, m1);
		expect_out(3, 130 * FT);
		expect_out(4, 130 * FT);
		wr(8'h18, 8'h00);
		settle();
		expect_out(2, 16'h0000);
		$display("duty mode and disable done");
		print_verdict();
	end
endmodule

// file: frame_pulse_checker_assertions.sv
// Purpose: port-level checks of the frame pulse generator and pin controls
// Assumes: shadows see every write; rate writes always include port 0
// Notes:   phase length is checked only after the first toggle since the last write
`timescale 1ns/1ps
module frame_pulse_checker #(
	parameter integer PIN_COUNT   = 4,
	parameter integer PORT_COUNT  = 2,
	parameter integer SLOT_COUNT  = 4,
	parameter integer FRAME_TICKS = 1200
) (
	input wire                             i_clk,
	input wire                             i_rst,
	input wire                             i_reg_wr,
	input wire                             i_reg_rd,
	input wire [7:0]                       i_reg_addr,
	input wire [7:0]                       i_reg_wdata,
	input wire [7:0]                       o_reg_rdata,
	input wire [PIN_COUNT-1:0]             i_pin_level,
	input wire [PIN_COUNT-1:0]             o_pin_input_en,
	input wire [PIN_COUNT-1:0]             o_pin_pulldown_en,
	input wire [PORT_COUNT*SLOT_COUNT-1:0] o_backchannel_slot,
	input wire                             o_frame_pulse
);
	reg  [7:0]  ctl_q;
	reg  [7:0]  rate_q;
	reg  [15:0] hi;
	reg  [15:0] lo;
	reg         prev_fp;
	reg         armed;
	integer     run;
	integer     lenx;
	always @* begin
		lenx = ctl_q[1] ? (hi >> 1) + (lo >> 1) : (prev_fp ? hi : lo);
		lenx = FRAME_TICKS * ((lenx == 0) ? 1 : lenx);
	end
	// any write may retime the generator, so the next toggle is not judged
	always @(posedge i_clk) begin
		prev_fp <= o_frame_pulse;
		run <= (o_frame_pulse != prev_fp) ? 1 : run + 1;
		armed <= (i_reg_wr || i_rst) ? 1'b0 : ((o_frame_pulse != prev_fp) && ctl_q[0]) | armed;
		if (i_rst) begin
			ctl_q <= 8'h00;
			rate_q <= 8'h00;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				8'h18: ctl_q <= i_reg_wdata;
				8'h19: hi[15:8] <= i_reg_wdata;
				8'h1A: hi[7:0] <= i_reg_wdata;
				8'h1B: lo[15:8] <= i_reg_wdata;
				8'h1C: lo[7:0] <= i_reg_wdata;
				8'h58: rate_q <= i_reg_wdata;
				default: ;
			endcase
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence off_steady;
		(!ctl_q[0] && !ctl_q[7] && $stable(ctl_q)) [*3];
	endsequence
	sequence gen_launch;
		$rose(ctl_q[0]);
	endsequence
	status_live_a: assert property (i_reg_rd && i_reg_addr == 8'h0E |-> o_reg_rdata[3:0] == i_pin_level)
		else $error("status read differs from pins");
	read_idle_a: assert property (!i_reg_rd |-> o_reg_rdata == 8'h00)
		else $error("read data not zero while idle");
	input_dis_a: assert property (i_reg_wr && i_reg_addr == 8'h0F |=> o_pin_input_en == ~$past(i_reg_wdata[3:0]))
		else $error("input enable does not follow write");
	pulldown_dis_a: assert property (i_reg_wr && i_reg_addr == 8'hBE |=> o_pin_pulldown_en == ~$past(i_reg_wdata[3:0]))
		else $error("pulldown enable does not follow write");
	reset_state_a: assert property ($fell(i_rst) |-> &o_pin_input_en && &o_pin_pulldown_en && !o_frame_pulse)
		else $error("outputs wrong after reset");
	off_hold_a: assert property (off_steady |-> o_frame_pulse == ctl_q[2])
		else $error("idle pulse not at start level");
	gen_start_a: assert property (gen_launch |=> o_frame_pulse == $past(ctl_q[2]))
		else $error("generation did not start at start level");
	phase_len_a: assert property (armed && ctl_q[0] && ctl_q[7:4] == 4'h0 && rate_q[2:0] == 3'h0 && o_frame_pulse != prev_fp |-> run == lenx)
		else $error("pulse phase length wrong");
endmodule
bind frame_pulse_backchannel_gpio frame_pulse_checker #(.PIN_COUNT(PIN_COUNT), .PORT_COUNT(PORT_COUNT),
	.SLOT_COUNT(SLOT_COUNT), .FRAME_TICKS(FRAME_TICKS)) checker_i (.i_clk(i_clk), .i_rst(i_rst),
	.i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
	.o_reg_rdata(o_reg_rdata), .i_pin_level(i_pin_level), .o_pin_input_en(o_pin_input_en),
	.o_pin_pulldown_en(o_pin_pulldown_en), .o_backchannel_slot(o_backchannel_slot),
	.o_frame_pulse(o_frame_pulse));

// file: pulse_tick_divider.v
// Purpose: one-cycle tick per back-channel frame period
// Assumes: only the 2.5 Mbps rate code gives the full period; others scale down by 2^code
// Notes:   count is a parameter so simulation can shorten it
`timescale 1ns/1ps
module pulse_tick_divider #(
	parameter integer FRAME_CYCLES = 1200
) (
	input  wire       i_clk,
	input  wire       i_rst,
	input  wire [2:0] i_rate_sel,
	output reg        o_tick
);
	reg  [15:0] count;
	wire [15:0] limit;

	// faster rates shorten the frame; only code 0 is characterised
	assign limit = (FRAME_CYCLES[15:0] >> i_rate_sel) - 16'h0001;

	always @(posedge i_clk) begin
		if (i_rst) begin
			count  <= 16'h0000;
			o_tick <= 1'b0;
		end else if (count >= limit) begin
			count  <= 16'h0000;
			o_tick <= 1'b1;
		end else begin
			count  <= count + 16'h0001;
			o_tick <= 1'b0;
		end
	end
endmodule

// file: remote_serializer_model.sv
// Purpose: remote serializer end, captures the back-channel slot bits of one port
// Assumes: slot bits arrive in the core clock domain
// Notes:   link timing not modelled, one register stage only
`timescale 1ns/1ps
module remote_serializer_model (
	input  wire       i_clk,
	input  wire       i_rst,
	input  wire [3:0] i_slot,
	output reg  [3:0] o_seen
);
	always @(posedge i_clk) begin
		o_seen <= i_rst ? 4'h0 : i_slot;
	end
endmodule
